/* File: rtl/tccs_chan.v */
`include "tccs_consts.vh"

module tccs_chan (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_run,
	input wire [4:0] i_edge_ctl,
	input wire i_direct,
	input wire i_src,
	input wire i_phase_mode,
	input wire i_phase_step,
	input wire i_clear,
	output reg [`TCCS_CNT_WIDTH-1:0] o_count,
	output reg o_overflow
);

reg prev_src;
reg tick;
wire rise;
wire fall;

assign rise = i_src & ~prev_src;
assign fall = ~i_src & prev_src;

always @* begin
	tick = 1'b0;
	if (i_run) begin
		if (i_phase_mode) begin
			tick = i_phase_step;
		end else if (i_direct) begin
			tick = i_src;
		end else if (i_edge_ctl[4]) begin
			tick = rise | fall;
		end else if (i_edge_ctl[3]) begin
			tick = fall;
		end else begin
			tick = rise;
		end
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		prev_src <= 1'b0;
		o_count <= {`TCCS_CNT_WIDTH{1'b0}};
		o_overflow <= 1'b0;
	end else begin
		prev_src <= i_src;
		o_overflow <= tick & (o_count == `TCCS_CNT_MAX) & ~i_clear;
		if (i_clear) begin
			o_count <= {`TCCS_CNT_WIDTH{1'b0}};
		end else if (tick) begin
			o_count <= o_count + 1'b1;
		end
	end
end

endmodule // tccs_chan

/* File: rtl/tccs_consts.vh */
`ifndef TCCS_CONSTS_VH
`define TCCS_CONSTS_VH

// register offsets on the plain register port
`define TCCS_OFS_CTL0 5'h00
`define TCCS_OFS_RUN 5'h05
`define TCCS_OFS_PHASE 5'h06
`define TCCS_OFS_CNT0 5'h10
`define TCCS_OFS_CNT_LAST 5'h19

// counter_control field positions and reset value
`define TCCS_CTL_RESET 8'h00
`define TCCS_CLR_HI 7
`define TCCS_CLR_LO 5
`define TCCS_EDGE_HI 4
`define TCCS_EDGE_LO 3
`define TCCS_CLK_HI 2
`define TCCS_CLK_LO 0
`define TCCS_CH12_MASK 8'h7F

// clear field low-bit codes
`define TCCS_CLR_NONE 2'h0
`define TCCS_CLR_A 2'h1
`define TCCS_CLR_B 2'h2
`define TCCS_CLR_SYNC 2'h3

// clock select codes
`define TCCS_CK_DIV1 3'h0
`define TCCS_CK_DIV4 3'h1
`define TCCS_CK_DIV16 3'h2
`define TCCS_CK_DIV64 3'h3
`define TCCS_CK_EXTA 3'h4
`define TCCS_CK_EXTB 3'h5
`define TCCS_CK_CODE6 3'h6
`define TCCS_CK_CODE7 3'h7

// prescaler bit whose level is the divided clock
`define TCCS_PRE_WIDTH 10
`define TCCS_PRE_DIV4 1
`define TCCS_PRE_DIV16 3
`define TCCS_PRE_DIV64 5
`define TCCS_PRE_DIV256 7
`define TCCS_PRE_DIV1024 9

`define TCCS_CNT_WIDTH 16
`define TCCS_CNT_MAX 16'hFFFF
`define TCCS_NCH 5

`endif

/* File: rtl/tccs_top.v */
// Summary of operation
// - five 8-bit read/write counter control registers, one per channel 0 to 4.
// - bits 7 to 5 select the event that clears the channel counter.
// - bits 4 to 3 select rising (00), falling (01) or both (1X) counting edges.
// - with both edges selected every rising and falling edge counts.
// - channels 1 and 2 in phase counting mode ignore the edge field.
// - edge selection on internal clocks applies for divide-by-four and slower.
// - with undivided clock or channel overflow the edge field is stored but acts as 00.
// - bits 2 to 0 select each channel's counter clock source independently.
// - clear codes x00 none, 001/010 on A/B, 101/110 on C/D, x11 with lockstep channels.
// - a C or D register used as buffer never clears the counter.
// - on channels 1 and 2 bit 7 reads zero and ignores writes.
// - clock codes 000 to 011 pick divide by 1, 4, 16, 64, 100 to 111 the pins, but channel 1 has 110 /256, 111 channel 2 overflow, channel 2 has 111 /1024.
//
// The placing of the registers and strobed register access are this design's own decisions.
`include "tccs_consts.vh"

module tccs_top (
	input wire i_clk,
	input wire i_rst_n,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire [3:0] i_ext_clock_in,
	input wire [4:0] i_match_a,
	input wire [4:0] i_match_b,
	input wire [4:0] i_match_c,
	input wire [4:0] i_match_d,
	input wire [4:0] i_buffer_c,
	input wire [4:0] i_buffer_d,
	input wire [4:0] i_lockstep,
	input wire [1:0] i_phase_step,
	output wire [4:0] o_overflow
);

////////////////////////////////////////////////////////////////////////////////
// storage

reg [7:0] counter_control [0:`TCCS_NCH-1];
reg [4:0] run;
reg [1:0] phase_mode;
reg [`TCCS_PRE_WIDTH-1:0] prescale;
wire [`TCCS_CNT_WIDTH-1:0] channel_counter [0:`TCCS_NCH-1];
reg [4:0] own_clear;
reg [4:0] clear;
reg [4:0] direct;
reg [4:0] src;
reg [7:0] next_rdata;
integer k;
integer m;

////////////////////////////////////////////////////////////////////////////////
// functions

// clock source mux per channel
// returns {direct, level}; direct sources count every high cycle
function [1:0] src_sel;
	input [2:0] ch;
	input [2:0] code;
	input [`TCCS_PRE_WIDTH-1:0] pre;
	input [3:0] ext;
	input ovf2;
	begin
		case (code)
			`TCCS_CK_DIV1: src_sel = {1'b1, 1'b1};
			`TCCS_CK_DIV4: src_sel = {1'b0, pre[`TCCS_PRE_DIV4]};
			`TCCS_CK_DIV16: src_sel = {1'b0, pre[`TCCS_PRE_DIV16]};
			`TCCS_CK_DIV64: src_sel = {1'b0, pre[`TCCS_PRE_DIV64]};
			`TCCS_CK_EXTA: src_sel = {1'b0, ext[0]};
			`TCCS_CK_EXTB: src_sel = {1'b0, ext[1]};
			`TCCS_CK_CODE6: begin
				if (ch == 3'h1) begin
					src_sel = {1'b0, pre[`TCCS_PRE_DIV256]};
				end else begin
					src_sel = {1'b0, ext[2]};
				end
			end
			`TCCS_CK_CODE7: begin
				if (ch == 3'h1) begin
					src_sel = {1'b1, ovf2};
				end else if (ch == 3'h2) begin
					src_sel = {1'b0, pre[`TCCS_PRE_DIV1024]};
				end else begin
					src_sel = {1'b0, ext[3]};
				end
			end
			default: src_sel = 2'h0;
		endcase
	end
endfunction

function own_clr;
	input [2:0] code;
	input ma;
	input mb;
	input mc;
	input md;
	input bc;
	input bd;
	begin
		case (code[1:0])
			`TCCS_CLR_A: begin
				own_clr = code[2] ? (mc & ~bc) : ma;
			end
			`TCCS_CLR_B: own_clr = code[2] ? (md & ~bd) : mb;
			default: own_clr = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// prescaler, free running so every channel sees the same phase

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		prescale <= {`TCCS_PRE_WIDTH{1'b0}};
	end else begin
		prescale <= prescale + 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// source and clear selection

always @* begin
	own_clear = 5'h00;
	clear = 5'h00;
	direct = 5'h00;
	src = 5'h00;
	for (k = 0; k < `TCCS_NCH; k = k + 1) begin
		own_clear[k] = own_clr(counter_control[k][`TCCS_CLR_HI:`TCCS_CLR_LO],
			i_match_a[k], i_match_b[k], i_match_c[k], i_match_d[k],
			i_buffer_c[k], i_buffer_d[k]);
		{direct[k], src[k]} = src_sel(k[2:0],
			counter_control[k][`TCCS_CLK_HI:`TCCS_CLK_LO],
			prescale, i_ext_clock_in, o_overflow[2]);
	end
	for (k = 0; k < `TCCS_NCH; k = k + 1) begin
		if (counter_control[k][`TCCS_CLR_LO+1:`TCCS_CLR_LO] == `TCCS_CLR_SYNC) begin
			clear[k] = i_lockstep[k] & |(own_clear & i_lockstep & ~(5'h01 << k));
		end else begin
			clear[k] = own_clear[k];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// channels

genvar g;
generate
	for (g = 0; g < `TCCS_NCH; g = g + 1) begin : g_ch
		tccs_chan u_chan (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_run(run[g]),
			.i_edge_ctl(counter_control[g][`TCCS_EDGE_HI:0]),
			.i_direct(direct[g]),
			.i_src(src[g]),
			.i_phase_mode((g == 1) ? phase_mode[0] : ((g == 2) ? phase_mode[1] : 1'b0)),
			.i_phase_step((g == 1) ? i_phase_step[0] : ((g == 2) ? i_phase_step[1] : 1'b0)),
			.i_clear(clear[g]),
			.o_count(channel_counter[g]),
			.o_overflow(o_overflow[g])
		);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// register port
// writes while a counter runs take effect at once; software should stop first

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		for (m = 0; m < `TCCS_NCH; m = m + 1) begin
			counter_control[m] <= `TCCS_CTL_RESET;
		end
		run <= 5'h00;
		phase_mode <= 2'h0;
	end else if (i_wr) begin
		if (i_addr < `TCCS_OFS_RUN) begin
			// bit 7 fixed low on channels 1, 2
			if (i_addr == 5'h01 || i_addr == 5'h02) begin
				counter_control[i_addr[2:0]] <= i_wdata & `TCCS_CH12_MASK;
			end else begin
				counter_control[i_addr[2:0]] <= i_wdata;
			end
		end else if (i_addr == `TCCS_OFS_RUN) begin
			run <= i_wdata[4:0];
		end else if (i_addr == `TCCS_OFS_PHASE) begin
			phase_mode <= i_wdata[1:0];
		end
	end
end

always @* begin
	next_rdata = 8'h00;
	if (i_addr < `TCCS_OFS_RUN) begin
		next_rdata = counter_control[i_addr[2:0]];
	end else if (i_addr == `TCCS_OFS_RUN) begin
		next_rdata = {3'h0, run};
	end else if (i_addr == `TCCS_OFS_PHASE) begin
		next_rdata = {6'h00, phase_mode};
	end else if (i_addr >= `TCCS_OFS_CNT0 && i_addr <= `TCCS_OFS_CNT_LAST) begin
		if (i_addr[0]) begin
			next_rdata = channel_counter[i_addr[3:1]][15:8];
		end else begin
			next_rdata = channel_counter[i_addr[3:1]][7:0];
		end
	end
end

// read data valid only in the cycle after the strobe
always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_rdata <= 8'h00;
	end else if (i_rd) begin
		o_rdata <= next_rdata;
	end else begin
		o_rdata <= 8'h00;
	end
end

endmodule // tccs_top

/* File: test/tccs_monitor.sv */
module tccs_monitor (
	input wire i_clk,
	input wire i_rst_n,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] o_rdata,
	input wire [4:0] i_match_a,
	input wire [4:0] i_match_d,
	input wire [4:0] i_buffer_d,
	input wire [4:0] o_overflow
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	reg [7:0] ctl0, ctl3;
	reg [4:0] run;
	// shadow copies so clear and run conditions are visible here
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl0 <= 8'h00;
			ctl3 <= 8'h00;
			run <= 5'h00;
		end else if (i_wr) begin
			if (i_addr == 5'h00)
				ctl0 <= i_wdata;
			if (i_addr == 5'h03)
				ctl3 <= i_wdata;
			if (i_addr == 5'h05)
				run <= i_wdata[4:0];
		end
	end
	sequence s_wr_full;
		i_wr && (i_addr == 5'h00 || i_addr == 5'h03 || i_addr == 5'h04);
	endsequence
	sequence s_rd_back;
		!i_wr ##1 i_rd && i_addr == $past(i_addr, 2);
	endsequence
	a_ctl_readback:
	assert property (s_wr_full ##1 s_rd_back |=> o_rdata == $past(i_wdata, 3))
		else $error("control readback differs");
	a_rdata_idle:
	assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero:
	assert property ($past(i_rd) && $past(i_addr) > 5'h19 |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_bit:
	assert property ($past(i_rd) && $past(i_addr) inside {5'h01, 5'h02} |-> !o_rdata[7])
		else $error("reserved bit read as one");
	a_ovf_single:
	assert property (o_overflow != 5'h00 |=> (o_overflow & $past(o_overflow)) == 5'h00)
		else $error("overflow longer than a cycle");
	a_ovf_needs_run:
	assert property ((o_overflow & ~($past(run) | $past(run, 2) | $past(run, 3))) == 5'h00)
		else $error("overflow while stopped");
	a_clear_a_wins:
	assert property (i_match_a[0] && ctl0[7:5] == 3'h1 |=> !o_overflow[0])
		else $error("overflow after clear");
	a_clear_d_wins:
	assert property (i_match_d[3] && !i_buffer_d[3] && ctl3[7:5] == 3'h6 |=> !o_overflow[3])
		else $error("overflow after clear");
endmodule // tccs_monitor
bind tccs_top tccs_monitor tccs_monitor_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_match_a(i_match_a),
	.i_match_d(i_match_d), .i_buffer_d(i_buffer_d), .o_overflow(o_overflow));

/* File: test/tccs_top_tb.sv */
module tccs_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	reg [4:0] i_addr = 5'h00, i_match_a = 5'h00, i_match_d = 5'h00, i_buffer_d = 5'h00;
	reg [4:0] i_match_b = 5'h00, i_match_c = 5'h00, i_buffer_c = 5'h00, i_lockstep = 5'h00;
	reg [7:0] i_wdata = 8'h00;
	reg [3:0] i_ext_clock_in = 4'h0;
	reg [1:0] i_phase_step = 2'h0;
	wire [7:0] o_rdata;
	wire [4:0] o_overflow;
	int error_cnt = 0, total_checks = 0, cycles = 0, ovf_seen = 0, exp_v;
	bit [31:0] seed = 32'hD933D61F;
	logic [7:0] d8;
	logic [15:0] base, val;
	// channel, control, run cycles, expected delta, slack, stimulus kind
	int tab [14][6] = '{'{0, 'h00, 20, 20, 0, 0}, '{0, 'h18, 20, 20, 0, 0},
		'{3, 'h01, 40, 10, 1, 0}, '{3, 'h09, 40, 10, 1, 0}, '{4, 'h11, 40, 20, 1, 0},
		'{2, 'h03, 640, 10, 1, 0}, '{0, 'h04, 40, 5, 0, 1}, '{0, 'h0C, 40, 5, 0, 1},
		'{0, 'h14, 40, 10, 0, 1}, '{1, 'h18, 40, 5, 0, 2}, '{0, 'h07, 40, 5, 0, 1},
		'{2, 'h18, 40, 5, 0, 2}, '{1, 'h06, 512, 2, 1, 0}, '{2, 'h07, 2048, 2, 1, 0}};
	tccs_top tccs_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clock_in(i_ext_clock_in),
		.i_match_a(i_match_a), .i_match_b(i_match_b), .i_match_c(i_match_c),
		.i_match_d(i_match_d), .i_buffer_c(i_buffer_c), .i_buffer_d(i_buffer_d),
		.i_lockstep(i_lockstep),
		.i_phase_step(i_phase_step), .o_overflow(o_overflow));
	always #50 i_clk = ~i_clk;
	////////////////////////////////////////
	function automatic bit [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
		total_checks++;
		if (!(got === exp || (tol > 0 && (got === exp + 16'h1 || got === exp - 16'h1)))) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input [4:0] a, input [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input [4:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// counter has no latch, so it is only read while stopped
	task cnt(input int ch, output logic [15:0] v);
		rd(5'(16 + 2 * ch), v[7:0]);
		rd(5'(17 + 2 * ch), v[15:8]);
	endtask
	task run(input int ch, input int n);
		wr(5'h05, 8'(1 << ch));
		repeat (n - 2) @(posedge i_clk);
		wr(5'h05, 8'h00);
	endtask
	task stim(input int mode);
		repeat (4) @(posedge i_clk);
		repeat (5) begin
			@(posedge i_clk);
			// all pins toggle together so every external code sees one pattern
			i_ext_clock_in <= {4{mode == 1}};
			i_phase_step <= {2{mode == 2}};
			@(posedge i_clk);
			i_phase_step <= 2'h0;
			repeat (2) @(posedge i_clk);
			i_ext_clock_in <= 4'h0;
			@(posedge i_clk);
		end
	endtask
	// m pulses the matches {d, c, b, a} of one channel for one cycle
	task clr(input int ch, input [7:0] ctl, input [3:0] m, input bit buf_on, input bit zero);
		wr(5'(ch), ctl);
		cnt(ch, base);
		@(posedge i_clk);
		i_buffer_c[ch] <= buf_on;
		i_buffer_d[ch] <= buf_on;
		i_match_a[ch] <= m[0];
		i_match_b[ch] <= m[1];
		i_match_c[ch] <= m[2];
		i_match_d[ch] <= m[3];
		@(posedge i_clk);
		i_match_a[ch] <= 1'b0;
		i_match_b[ch] <= 1'b0;
		i_match_c[ch] <= 1'b0;
		i_match_d[ch] <= 1'b0;
		cnt(ch, val);
		chk(val, zero ? 16'h0000 : base, 0);
	endtask
	task results();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (o_overflow[4] === 1'b1)
			ovf_seen <= ovf_seen + 1;
		if (cycles == 90000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			rd(5'(c), d8);
			chk(d8, 0, 0);
			exp_v = (xs() & 'hFF) | 'h80;
			wr(5'(c), 8'(exp_v));
			rd(5'(c), d8);
			chk(d8, (c == 1 || c == 2) ? exp_v & 'h7F : exp_v, 0);
		end
		rd(5'h1F, d8);
		chk(d8, 0, 0);
		for (int i = 0; i < 14; i++) begin
			wr(5'h06, (tab[i][5] == 2) ? 8'h03 : 8'h00);
			wr(5'(tab[i][0]), 8'(tab[i][1])); // written while stopped
			cnt(tab[i][0], base);
			fork
				run(tab[i][0], tab[i][2]);
				stim(tab[i][5]);
			join
			cnt(tab[i][0], val);
			chk(val - base, 16'(tab[i][3]), tab[i][4]);
		end
		clr(0, 8'hA0, 4'h9, 1'b0, 1'b0);
		clr(0, 8'h20, 4'h9, 1'b0, 1'b1);
		run(0, 8);
		clr(0, 8'hA0, 4'h4, 1'b0, 1'b1);
		clr(2, 8'h40, 4'h1, 1'b0, 1'b0);
		clr(2, 8'h40, 4'h2, 1'b0, 1'b1);
		clr(3, 8'hA0, 4'h4, 1'b1, 1'b0);
		clr(3, 8'hC0, 4'h9, 1'b1, 1'b0);
		clr(3, 8'hC0, 4'h9, 1'b0, 1'b1);
		// lockstep pair: channel 4 clears on its own match, channel 1 follows
		i_lockstep <= 5'h12;
		wr(5'h01, 8'h60);
		clr(4, 8'h20, 4'h1, 1'b0, 1'b1);
		cnt(1, val);
		chk(val, 16'h0000, 0);
		i_lockstep <= 5'h00;
		wr(5'h04, 8'h00);
		cnt(4, base);
		run(4, 65540);
		cnt(4, val);
		exp_v = base + 65540;
		chk(val, 16'(exp_v), 0);
		chk(16'(ovf_seen), 16'(exp_v >> 16), 0);
		results();
	end
endmodule // tccs_top_tb
